/* motor_drive_map.vh */
// motor drive pulse control: register offsets, fields, reset values, timing
// included by the design files; defines only
`ifndef MOTOR_DRIVE_MAP_VH
`define MOTOR_DRIVE_MAP_VH

`define ADDR_CTRL        4'h0
`define ADDR_PULSE_TIME  4'h1
`define ADDR_PAUSE_TIME  4'h2
`define ADDR_RUN_LIMIT   4'h3
`define ADDR_STATUS      4'h4
`define ADDR_IRQ_MASK    4'h5
`define ADDR_STATE       4'h6

`define CTRL_TIMED_BIT     0
`define CTRL_SWAP_BIT      1
`define CTRL_RUNMON_BIT    2
`define CTRL_DIRMON_BIT    3
`define CTRL_RESET         32'h0000_0000

`define EV_RUNTIME_BIT     0
`define EV_DIRECTION_BIT   1
`define EV_DONE_BIT        2
`define EV_WIDTH           3

`define TIME_UNIT_MS       1
`define CLK_HZ             20000000
`define CYCLES_PER_MS      ((`CLK_HZ / 1000) * `TIME_UNIT_MS)
`define PULSE_TIME_RESET   32'h0000_05dc
`define PAUSE_TIME_RESET   32'h0000_03e8
`define RUN_LIMIT_RESET    32'h0000_2710
`define TRIP_PULSE_MS      200
`define TRIP_PULSE_CYCLES  (`TRIP_PULSE_MS * `CYCLES_PER_MS)

`endif

/* ms_timer.v */
// millisecond timer: counts whole ms while run is high, clears when run is low
// assumes sys_clk at the rate in motor_drive_map.vh
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_map.vh"

module ms_timer #(
   parameter integer TICK_CYCLES = `CYCLES_PER_MS
) (
   input wire sys_clk,
   input wire rst,
   input wire run,
   output reg [31:0] ms_count
);

reg [31:0] tick;

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      tick <= 32'h0;
      ms_count <= 32'h0;
   end
   else if (!run)
   begin
      tick <= 32'h0;
      ms_count <= 32'h0;
   end
   else if (tick == TICK_CYCLES - 1)
   begin
      tick <= 32'h0;
      ms_count <= ms_count + 32'h1;
   end
   else
      tick <= tick + 32'h1;
end

endmodule // ms_timer
`default_nettype wire

/* trip_pulse.v */
// fixed-length pulse stretcher for the protective switch relay
// start is a one-cycle request, retriggering restarts the length
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_map.vh"

module trip_pulse #(
   parameter integer LEN_CYCLES = `TRIP_PULSE_CYCLES
) (
   input wire sys_clk,
   input wire rst,
   input wire start,
   output reg pulse
);

reg [31:0] left;

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      left <= 32'h0;
      pulse <= 1'b0;
   end
   else if (start)
   begin
      left <= LEN_CYCLES - 1;
      pulse <= 1'b1;
   end
   else if (left != 32'h0)
      left <= left - 32'h1;
   else
      pulse <= 1'b0;
end

endmodule // trip_pulse
`default_nettype wire

/* motor_drive_pulse_control.v */
// Functional notes
// RQ1 - pulse type bit picks continuous or time-limited switching pulses
// RQ2 - continuous auto: pulse held until measurement back inside bandwidth
// RQ3 - continuous manual: pulse only while operator raise/lower held
// RQ4 - continuous follower: end on runtime, running fall, or master tap reached
// RQ5 - timed: end at pulse time, or earlier on running or tap change
// RQ6 - after each pulse a pause must fully elapse before the next
// RQ7 - motor unit holds running high for the whole tap change
// RQ8 - when enabled, time motor running against runtime limit
// RQ9 - over limit: runtime event and protective switch trip pulse
// RQ10 - runtime monitoring disabled: no check, event or trip
// RQ11 - wrong-direction tap change raises event, blocks auto until acknowledged
// RQ12 - direction monitoring suppressed in continuous mode
// RQ13 - standard maps increase to raise; swapped exchanges the outputs
// RQ14 - never raise and lower together; requests ignored during pulse or pause
//
// register port: one-cycle strobes, read data valid the cycle after read
// times in registers are in milliseconds; tap_up/tap_down are one-cycle pulses
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_map.vh"

module motor_drive_pulse_control #(
   parameter integer TICK_CYCLES = `CYCLES_PER_MS,
   parameter integer TRIP_CYCLES = `TRIP_PULSE_CYCLES
) (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire automatic_regulation_mode,
   input wire manual_regulation_mode,
   input wire follower_mode,
   input wire auto_increase,
   input wire auto_decrease,
   input wire in_bandwidth,
   input wire manual_increase,
   input wire manual_decrease,
   input wire master_tap_reached,
   input wire motor_running,
   input wire tap_up,
   input wire tap_down,
   output reg raise_out,
   output reg lower_out,
   output reg trip_out,
   output reg auto_blocked,
   output reg irq
);

localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_PULSE = 4'b0010;
localparam [3:0] ST_PAUSE = 4'b0100;
localparam [3:0] ST_SPARE = 4'b1000;

////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] ctrl;
reg [31:0] pulse_time;
reg [31:0] pause_time;
reg [31:0] run_limit;
reg [`EV_WIDTH-1:0] status;
reg [`EV_WIDTH-1:0] irq_mask;
reg [3:0] state;
reg cmd_increase;
reg cmd_manual;
reg running_q;
reg runtime_flagged;
reg [`EV_WIDTH-1:0] ev_set;

wire timed = ctrl[`CTRL_TIMED_BIT];
wire swap = ctrl[`CTRL_SWAP_BIT];
wire runmon = ctrl[`CTRL_RUNMON_BIT];
wire dirmon = ctrl[`CTRL_DIRMON_BIT];
wire pulse_active = (state == ST_PULSE);
wire [31:0] state_ms;
wire [31:0] run_ms;
wire trip_pulse_q;
wire state_timer_run;
wire [`EV_WIDTH-1:0] clr_bits = (reg_wr && reg_addr == `ADDR_STATUS) ?
   reg_wdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      ctrl <= `CTRL_RESET;
      pulse_time <= `PULSE_TIME_RESET;
      pause_time <= `PAUSE_TIME_RESET;
      run_limit <= `RUN_LIMIT_RESET;
      irq_mask <= {`EV_WIDTH{1'b0}};
   end
   else if (reg_wr)
   begin
      case (reg_addr)
         `ADDR_CTRL: ctrl <= {28'h0, reg_wdata[3:0]};
         `ADDR_PULSE_TIME: pulse_time <= reg_wdata;
         `ADDR_PAUSE_TIME: pause_time <= reg_wdata;
         `ADDR_RUN_LIMIT: run_limit <= reg_wdata;
         `ADDR_IRQ_MASK: irq_mask <= reg_wdata[`EV_WIDTH-1:0];
         default: ;
      endcase
   end
end

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
      reg_rdata <= 32'h0;
   else if (reg_rd)
   begin
      case (reg_addr)
         `ADDR_CTRL: reg_rdata <= ctrl;
         `ADDR_PULSE_TIME: reg_rdata <= pulse_time;
         `ADDR_PAUSE_TIME: reg_rdata <= pause_time;
         `ADDR_RUN_LIMIT: reg_rdata <= run_limit;
         `ADDR_STATUS: reg_rdata <= {29'h0, status};
         `ADDR_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
         `ADDR_STATE: reg_rdata <= {26'h0, auto_blocked, motor_running, state};
         default: reg_rdata <= 32'h0;
      endcase
   end
   else
      reg_rdata <= 32'h0;
end

////////////////////////////////////////////////////////////////////////////
// timers: one for pulse/pause length, one for motor running

ms_timer #(
   .TICK_CYCLES(TICK_CYCLES)
) u_state_timer (
   .sys_clk(sys_clk),
   .rst(rst),
   .run(state_timer_run),
   .ms_count(state_ms)
);

ms_timer #(
   .TICK_CYCLES(TICK_CYCLES)
) u_run_timer (
   .sys_clk(sys_clk),
   .rst(rst),
   .run(motor_running),
   .ms_count(run_ms)
);

////////////////////////////////////////////////////////////////////////////
// request selection and pulse end

reg req_any;
reg req_increase;
reg req_manual;
reg pulse_end;

always @*
begin
   req_any = 1'b0;
   req_increase = 1'b0;
   req_manual = 1'b0;
   // manual wins over auto; both directions at once is ignored
   if (manual_regulation_mode && (manual_increase ^ manual_decrease))
   begin
      req_any = 1'b1;
      req_increase = manual_increase;
      req_manual = 1'b1;
   end
   else if (automatic_regulation_mode && !auto_blocked && !in_bandwidth &&
            (auto_increase ^ auto_decrease))
   begin
      req_any = 1'b1;
      req_increase = auto_increase;
   end
end

wire tap_changed = tap_up | tap_down;
wire running_fell = running_q & ~motor_running;

always @*
begin
   pulse_end = 1'b0;
   if (timed)
      pulse_end = (state_ms >= pulse_time) || motor_running || tap_changed; // [RQ5]
   else if (cmd_manual)
      pulse_end = !manual_regulation_mode ||
         !(cmd_increase ? manual_increase : manual_decrease); // [RQ3]
   else if (follower_mode)
      pulse_end = (state_ms >= run_limit) || running_fell || master_tap_reached; // [RQ4]
   else
      pulse_end = in_bandwidth || !automatic_regulation_mode || auto_blocked; // [RQ2]
end

// timer drops for the end cycle, else the pause would inherit the pulse's time
assign state_timer_run = (pulse_active && !pulse_end) || (state == ST_PAUSE); // [RQ6]

////////////////////////////////////////////////////////////////////////////
// pulse / pause sequencer

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      state <= ST_IDLE;
      cmd_increase <= 1'b0;
      cmd_manual <= 1'b0;
   end
   else
   begin
      case (state)
         ST_IDLE:
         begin
            if (req_any) // [RQ1]
            begin
               state <= ST_PULSE;
               cmd_increase <= req_increase;
               cmd_manual <= req_manual;
            end
         end
         ST_PULSE:
         begin
            // new requests are not looked at here
            if (pulse_end) // [RQ14]
               state <= ST_PAUSE;
         end
         ST_PAUSE:
         begin
            if (state_ms >= pause_time) // [RQ6]
               state <= ST_IDLE;
         end
         default: state <= ST_IDLE;
      endcase
   end
end

// one path drives both relays so they can never overlap
always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      raise_out <= 1'b0;
      lower_out <= 1'b0;
   end
   else if (state == ST_PULSE && !pulse_end)
   begin
      raise_out <= cmd_increase ^ swap; // [RQ13] [RQ14]
      lower_out <= ~(cmd_increase ^ swap); // [RQ13] [RQ14]
   end
   else
   begin
      raise_out <= 1'b0;
      lower_out <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////
// runtime and direction monitoring

// relies on running staying high for the whole tap change
wire runtime_over = runmon && motor_running && (run_ms > run_limit) &&
   !runtime_flagged; // [RQ7] [RQ8] [RQ10]

// a change opposite to the last command, seen during a pulse or its pause
wire dir_fault = dirmon && timed && (state != ST_IDLE) &&
   (cmd_increase ? (swap ? tap_up : tap_down) : (swap ? tap_down : tap_up)); // [RQ11] [RQ12]

always @*
begin
   ev_set = {`EV_WIDTH{1'b0}};
   ev_set[`EV_RUNTIME_BIT] = runtime_over; // [RQ9]
   ev_set[`EV_DIRECTION_BIT] = dir_fault; // [RQ11]
   ev_set[`EV_DONE_BIT] = pulse_active && pulse_end;
end

trip_pulse #(
   .LEN_CYCLES(TRIP_CYCLES)
) u_trip (
   .sys_clk(sys_clk),
   .rst(rst),
   .start(runtime_over), // [RQ9]
   .pulse(trip_pulse_q)
);

always @(posedge sys_clk or posedge rst)
begin
   if (rst)
   begin
      running_q <= 1'b0;
      runtime_flagged <= 1'b0;
      status <= {`EV_WIDTH{1'b0}};
      auto_blocked <= 1'b0;
      trip_out <= 1'b0;
      irq <= 1'b0;
   end
   else
   begin
      running_q <= motor_running;
      // one trip per run of the motor
      if (!motor_running)
         runtime_flagged <= 1'b0;
      else if (runtime_over)
         runtime_flagged <= 1'b1;
      status <= (status & ~clr_bits) | ev_set;
      // block lasts until software acknowledges the direction event
      auto_blocked <= (status[`EV_DIRECTION_BIT] & ~clr_bits[`EV_DIRECTION_BIT]) |
         ev_set[`EV_DIRECTION_BIT]; // [RQ11]
      trip_out <= trip_pulse_q & runmon; // [RQ10]
      irq <= |(((status & ~clr_bits) | ev_set) & irq_mask);
   end
end

endmodule // motor_drive_pulse_control
`default_nettype wire

/* motor_drive_pulse_control_asserts.sv */
// checker on the motor drive pulse control ports
// assumes one clock; ctrl bits mirrored from register writes
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_map.vh"
module motor_drive_pulse_control_asserts (
   input wire sys_clk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire automatic_regulation_mode,
   input wire manual_regulation_mode,
   input wire manual_increase,
   input wire manual_decrease,
   input wire motor_running,
   input wire raise_out,
   input wire lower_out,
   input wire trip_out,
   input wire auto_blocked
);
logic [3:0] ctrl;
wire out = raise_out | lower_out;
always @(posedge sys_clk or posedge rst)
   if (rst)
      ctrl <= 4'h0;
   else if (reg_wr && reg_addr == `ADDR_CTRL)
      ctrl <= reg_wdata[3:0];
////////////////////////////////////////
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
a_relays_exclusive:
   assert property (!(raise_out && lower_out)) else $error("both relays");
a_pause_after:
   assert property ($fell(out) |-> !out [*8]) else $error("pause short");
a_trip_len:
   assert property ($rose(trip_out) |-> trip_out [*8]) else $error("trip short");
a_trip_enable:
   assert property ($rose(trip_out) |-> ctrl[2]) else $error("trip while off");
a_manual_release:
   assert property (!ctrl[0] && manual_regulation_mode && !manual_increase
      && !manual_decrease && out |-> ##[1:2] !out) else $error("held after release");
a_timed_stop:
   assert property (ctrl[0] && motor_running && out |-> ##[1:2] !out) else $error("timed");
a_swap_map:
   assert property (manual_regulation_mode && manual_increase && !manual_decrease && out
      |-> raise_out != ctrl[1]) else $error("wrong relay");
a_block_auto:
   assert property ($rose(out) && automatic_regulation_mode && !manual_regulation_mode
      |-> !auto_blocked && !$past(auto_blocked)) else $error("auto while blocked");
a_dir_timed:
   assert property ($rose(auto_blocked) |-> ctrl[0] && ctrl[3]) else $error("dir fault");
c_trip: cover property ($rose(trip_out));
c_block: cover property ($rose(auto_blocked));
c_pause: cover property ($fell(out) && ctrl[0]);
endmodule // motor_drive_pulse_control_asserts
bind motor_drive_pulse_control motor_drive_pulse_control_asserts u_chk (.sys_clk(sys_clk),
   .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .automatic_regulation_mode(automatic_regulation_mode),
   .manual_regulation_mode(manual_regulation_mode), .manual_increase(manual_increase),
   .manual_decrease(manual_decrease), .motor_running(motor_running), .raise_out(raise_out),
   .lower_out(lower_out), .trip_out(trip_out), .auto_blocked(auto_blocked));
`default_nettype wire

/* motor_unit_model.sv */
// motor drive unit: runs the motor once per rising relay command
// assumes relay levels from the pulse control block, same clock
`timescale 1ns/1ps
`default_nettype none
module motor_unit_model (
   input wire logic sys_clk,
   input wire logic raise,
   input wire logic lower,
   input wire logic [15:0] lag,
   input wire logic [15:0] run_len,
   input wire logic wrong_dir,
   output logic motor_running,
   output logic tap_up,
   output logic tap_down
);
logic was = 0, up = 0;
int cnt = 0;
////////////////////////////////////////
always @(posedge sys_clk)
begin
   was <= raise | lower;
   tap_up <= 0;
   tap_down <= 0;
   if (cnt == 0 && (raise | lower) && !was)
   begin
      cnt <= lag + run_len;
      up <= raise ^ wrong_dir;
   end
   else if (cnt > 0)
      cnt <= cnt - 1;
   motor_running <= cnt > 1 && cnt <= run_len + 1;
   if (cnt == 1)
   begin
      // tap step reported as running drops
      tap_up <= up;
      tap_down <= !up;
   end
end
endmodule // motor_unit_model
`default_nettype wire

/* motor_drive_pulse_control_tb.sv */
// bench for the pulse control block: random and corner scenarios
// assumes motor_unit_model on the relay side, 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "motor_drive_map.vh"
module motor_drive_pulse_control_tb;
logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, follower_mode = 0, wrong = 0;
logic automatic_regulation_mode = 0, manual_regulation_mode = 0, auto_increase = 0;
logic auto_decrease = 0, in_bandwidth = 1, manual_increase = 0, manual_decrease = 0;
logic master_tap_reached = 0;
logic [3:0] reg_addr = 0;
logic [31:0] reg_wdata = 0, seed = 32'hd014;
logic [15:0] lag = 1, run_len = 3;
wire [31:0] reg_rdata;
wire motor_running, tap_up, tap_down, raise_out, lower_out, trip_out, auto_blocked, irq;
int mismatches = 0, n_compared = 0, n, i;
always #25 sys_clk = ~sys_clk;
motor_drive_pulse_control #(.TICK_CYCLES(4), .TRIP_CYCLES(10)) u_dut (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .automatic_regulation_mode(automatic_regulation_mode),
   .manual_regulation_mode(manual_regulation_mode), .follower_mode(follower_mode),
   .auto_increase(auto_increase), .auto_decrease(auto_decrease), .in_bandwidth(in_bandwidth),
   .manual_increase(manual_increase), .manual_decrease(manual_decrease),
   .master_tap_reached(master_tap_reached), .motor_running(motor_running), .tap_up(tap_up),
   .tap_down(tap_down), .raise_out(raise_out), .lower_out(lower_out), .trip_out(trip_out),
   .auto_blocked(auto_blocked), .irq(irq));
motor_unit_model u_motor (.sys_clk(sys_clk), .raise(raise_out), .lower(lower_out), .lag(lag),
   .run_len(run_len), .wrong_dir(wrong), .motor_running(motor_running), .tap_up(tap_up),
   .tap_down(tap_down));
////////////////////////////////////////
function automatic logic [31:0] rnd();
   seed ^= seed << 13;
   seed ^= seed >> 17;
   seed ^= seed << 5;
   return seed;
endfunction
// standard: increase on raise; swapped: increase on lower
function automatic logic exp_raise(input logic inc, input logic swp);
   return inc ^ swp;
endfunction
task cyc(input int c);
   repeat (c) @(posedge sys_clk);
endtask
task chk(input string s, input logic [31:0] e, input logic [31:0] g);
   n_compared++;
   if (e !== g)
   begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
   end
endtask
task wr(input logic [3:0] a, input logic [31:0] d);
   reg_addr <= a;
   reg_wdata <= d;
   reg_wr <= 1;
   cyc(1);
   reg_wr <= 0;
   cyc(1);
endtask
task rd(input logic [3:0] a, input logic [31:0] e, input string s);
   reg_addr <= a;
   reg_rd <= 1;
   cyc(1);
   reg_rd <= 0;
   cyc(1);
   chk(s, e, reg_rdata);
endtask
function automatic logic pick(input int s);
   return s ? trip_out : raise_out | lower_out;
endfunction
// samples before each edge, so the count is whole cycles high
task width(input int s, output int len);
   int k;
   len = 0;
   for (k = 0; k < 300 && !pick(s); k++)
      cyc(1);
   while (pick(s) && len < 300)
   begin
      cyc(1);
      len++;
   end
endtask
task shot(output int len);
   manual_increase <= 1;
   width(0, len);
   manual_increase <= 0;
endtask
task stop_test;
   $display("compared %0d mismatches %0d", n_compared, mismatches);
   if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
initial
begin
   cyc(20);
   rst <= 0;
   cyc(1);
   rd(`ADDR_PAUSE_TIME, `PAUSE_TIME_RESET, "pause_time");
   rd(`ADDR_STATE, 32'h1, "state after reset");
   wr(4'hf, rnd());
   rd(4'hf, 32'h0, "unmapped");
   wr(`ADDR_PAUSE_TIME, 32'h2);
   wr(`ADDR_PULSE_TIME, 32'h3);
   wr(`ADDR_RUN_LIMIT, 32'h2);
   manual_regulation_mode <= 1;
   for (i = 0; i < 4; i++)
   begin
      wr(`ADDR_CTRL, {30'h0, i[1], 1'b0});
      {manual_increase, manual_decrease} <= i[0] ? 2'b10 : 2'b01;
      cyc(4 + rnd() % 16);
      chk("raise", exp_raise(i[0], i[1]), raise_out);
      chk("lower", !exp_raise(i[0], i[1]), lower_out);
      {manual_increase, manual_decrease} <= 2'b00;
      cyc(3);
      chk("release", 0, raise_out | lower_out);
      manual_increase <= 1;
      cyc(4);
      chk("in pause", 0, raise_out | lower_out);
      manual_increase <= 0;
      cyc(20);
   end
   $display("test manual done");
   wr(`ADDR_CTRL, 32'h1);
   lag <= 100;
   shot(n);
   chk("timed", 1, n >= 11 && n <= 14);
   cyc(150);
   lag <= 1;
   shot(n);
   chk("early end", 1, n <= 5);
   cyc(20);
   wr(`ADDR_CTRL, 32'h5);
   wr(`ADDR_IRQ_MASK, 32'h1);
   for (i = 0; i < 2; i++)
   begin
      wr(`ADDR_STATUS, 32'h7);
      run_len <= 40;
      shot(n);
      width(1, n);
      chk("trip", i ? 0 : 10, n);
      cyc(40);
      rd(`ADDR_STATUS, i ? 32'h4 : 32'h5, "status");
      chk("irq", !i, irq);
      wr(`ADDR_IRQ_MASK, 32'h0);
      cyc(2);
      chk("masked", 0, irq);
      wr(`ADDR_IRQ_MASK, 32'h1);
      wr(`ADDR_STATUS, 32'h1);
      cyc(2);
      chk("cleared", 0, irq);
      wr(`ADDR_CTRL, 32'h1);
   end
   $display("test runtime done");
   run_len <= 3;
   wrong <= 1;
   wr(`ADDR_CTRL, 32'h9);
   wr(`ADDR_STATUS, 32'h7);
   shot(n);
   cyc(20);
   chk("blocked", 1, auto_blocked);
   rd(`ADDR_STATUS, 32'h6, "dir event");
   manual_regulation_mode <= 0;
   automatic_regulation_mode <= 1;
   auto_increase <= 1;
   in_bandwidth <= 0;
   width(0, n);
   chk("auto held", 0, n);
   wrong <= 0;
   wr(`ADDR_STATUS, 32'h7);
   width(0, n);
   in_bandwidth <= 1;
   chk("unblocked", 1, n > 0);
   automatic_regulation_mode <= 0;
   manual_regulation_mode <= 1;
   wrong <= 1;
   wr(`ADDR_CTRL, 32'h8);
   manual_increase <= 1;
   cyc(10);
   manual_increase <= 0;
   cyc(20);
   chk("no dir fault", 0, auto_blocked);
   $display("test direction done");
   wrong <= 0;
   wr(`ADDR_CTRL, 32'h0);
   wr(`ADDR_RUN_LIMIT, 32'h32);
   lag <= 400;
   manual_regulation_mode <= 0;
   automatic_regulation_mode <= 1;
   for (i = 0; i < 2; i++)
   begin
      follower_mode <= i[0];
      in_bandwidth <= 0;
      {auto_increase, auto_decrease} <= i ? 2'b01 : 2'b10;
      cyc(16 + rnd() % 8);
      chk("auto on", 1, i ? lower_out : raise_out);
      if (i)
         master_tap_reached <= 1;
      else
         in_bandwidth <= 1;
      cyc(3);
      chk("auto off", 0, raise_out | lower_out);
      cyc(20);
   end
   // follower ended by the motor's running signal falling
   in_bandwidth <= 1;
   master_tap_reached <= 0;
   lag <= 4;
   cyc(420);
   in_bandwidth <= 0;
   width(0, n);
   in_bandwidth <= 1;
   chk("running fell", 1, n >= 5 && n <= 12);
   // follower ended by the pulse time reaching the run limit: 4 ms of 4 cycles
   wr(`ADDR_RUN_LIMIT, 32'h4);
   lag <= 400;
   cyc(20);
   in_bandwidth <= 0;
   width(0, n);
   in_bandwidth <= 1;
   chk("run limit", 16, n);
   $display("test auto done");
   stop_test;
end
initial
begin
   cyc(20000);
   mismatches++;
   stop_test;
end
endmodule // motor_drive_pulse_control_tb
`default_nettype wire
